// ===== design/lcdfc_pkg.sv
// Constants shared by the segment LCD frame controller
package lcdfc_pkg;
   // Panel geometry
   localparam int N_COM = 4;
   localparam int N_SEG = 40;
   localparam int BYTES_PER_COM = 5;
   localparam int DMEM_BYTES = 20;
   // Register offsets
   localparam logic [5:0] OFS_CTRL = 6'h00;
   localparam logic [5:0] OFS_TIMING = 6'h01;
   localparam logic [5:0] OFS_XINT = 6'h02;
   localparam logic [5:0] OFS_STATUS = 6'h03;
   localparam logic [5:0] OFS_BLINK_CTRL = 6'h04;
   localparam logic [5:0] OFS_BLINK_SEL = 6'h05;
   localparam logic [5:0] OFS_ASCII = 6'h06;
   localparam logic [5:0] OFS_DIGIT = 6'h07;
   localparam logic [5:0] OFS_DMEM = 6'h10;
   // Control register fields
   localparam int CTRL_ENABLE = 7;
   localparam int CTRL_DATA_LOCK = 5;
   localparam int CTRL_CLEAR = 2;
   localparam int CTRL_SEG_ON = 1;
   localparam int CTRL_BLANK = 0;
   // Timing register fields
   localparam int TIM_PRESCALE = 7;
   localparam int TIM_DIV_LSB = 4;
   localparam int TIM_LOW_POWER = 3;
   localparam int TIM_DUTY_LSB = 0;
   // Status register fields
   localparam int STAT_FLAG = 0;
   localparam int STAT_BLANKED = 1;
   localparam int STAT_COM_LSB = 2;
   localparam int STAT_BLINK_OFF = 4;
   // Blink control fields
   localparam int BLK_ENABLE = 3;
   localparam int BLK_RATE_LSB = 0;
   // Digit control fields
   localparam int DIG_TYPE_LSB = 0;
   localparam int DIG_BASE_LSB = 2;
   // Reset values
   localparam logic [7:0] RST_CTRL = 8'h00;
   localparam logic [7:0] RST_TIMING = 8'h00;
   localparam logic [4:0] RST_XINT = 5'h00;
   localparam logic [7:0] RST_BLINK_CTRL = 8'h00;
   localparam logic [7:0] RST_BLINK_SEL = 8'h00;
   localparam logic [7:0] RST_DIGIT = 8'h00;
   // Prescaler terminal counts for divide by 8 and by 16
   localparam logic [3:0] RIPPLE_TC_8 = 4'h7;
   localparam logic [3:0] RIPPLE_TC_16 = 4'hF;
   // Frames per blink half period at the fastest rate code
   localparam logic [7:0] BLINK_BASE = 8'h04;
   // Pin drive level codes, one-third bias
   localparam logic [1:0] LVL_GND = 2'h0;
   localparam logic [1:0] LVL_THIRD = 2'h1;
   localparam logic [1:0] LVL_TWO_THIRD = 2'h2;
   localparam logic [1:0] LVL_FULL = 2'h3;
endpackage : lcdfc_pkg

// ===== design/lcdfc_top.sv
// Segment LCD frame controller: prescaler, frame scan, shadow memory, blink and decoder
// Notes on behaviour
// [R1] Ripple prescaler divides the LCD clock by 8 or 16 per prescale select.
// [R2] Frame clock divider divides further by 1 to 8; result times frames.
// [R3] Display memory is copied into shadow memory at every frame start.
// [R4] A set display bit energizes its segment, a clear bit leaves it off.
// [R5] Each frame starts on the first common using that common's shadow data.
// [R6] Commons follow one by one up to the count chosen by duty.
// [R7] Off segments drive in phase with addressed common, on segments opposite.
// [R8] Multi-common duty uses two intermediate levels; static to quarter duty supported.
// [R9] Low power waveform alternates polarity per frame; flag every two frames.
// [R10] Controller and blinking keep running in every sleep mode.
// [R11] Digit decoder writes the ASCII segment pattern itself; four mapping types.
// [R12] Blanking waits for frame end, then grounds all pins; memory kept.
// [R13] Segments-on clear keeps waveform running but shows every segment off.
// [R14] Software may blink by toggling segments-on or rewriting display memory.
// [R15] Hardware blink on first two segment terminals, selected commons, set rate.
// [R16] A blinking segment shows only when its display bit is set.
// [R17] Blink enabled with no common selected blinks all enabled segments.
// [R18] Blink disabled follows data; nonzero select restricts blinking to selection.
// [R19] Blink configuration changes apply at the next frame start.
// [R20] Frame interrupt every frame at field zero, else every field plus one.
// [R21] LCD clock comes from an asynchronous 32 kHz source.
// [R22] Data lock freezes the shadow memory; clearing it resumes frame copies.
// [R23] Frame flag set at chosen frame boundary and held until software clears.
//
// The implementer's own choices: the plain strobed port and the register addresses.
`timescale 1ns/10ps
`default_nettype none
module lcdfc_top (
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic lcd_clk_in,
   input wire logic [5:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [7:0] reg_rdata,
   output logic [7:0] com_level,
   output logic [79:0] seg_level,
   output logic frame_flag
);
   // Number of commons addressed for a duty code
   function automatic logic [2:0] lcdfc_num_coms(input logic [1:0] duty);
      unique case (duty)
         2'h0: lcdfc_num_coms = 3'h4;
         2'h1: lcdfc_num_coms = 3'h1;
         2'h2: lcdfc_num_coms = 3'h2;
         2'h3: lcdfc_num_coms = 3'h3;
      endcase
   endfunction : lcdfc_num_coms

   // Seven segment pattern for an ASCII code, bit 0 is segment a
   function automatic logic [7:0] lcdfc_glyph(input logic [7:0] code);
      case (code)
         8'h30: lcdfc_glyph = 8'h3F;
         8'h31: lcdfc_glyph = 8'h06;
         8'h32: lcdfc_glyph = 8'h5B;
         8'h33: lcdfc_glyph = 8'h4F;
         8'h34: lcdfc_glyph = 8'h66;
         8'h35: lcdfc_glyph = 8'h6D;
         8'h36: lcdfc_glyph = 8'h7D;
         8'h37: lcdfc_glyph = 8'h07;
         8'h38: lcdfc_glyph = 8'h7F;
         8'h39: lcdfc_glyph = 8'h6F;
         8'h41, 8'h61: lcdfc_glyph = 8'h77;
         8'h42, 8'h62: lcdfc_glyph = 8'h7C;
         8'h43, 8'h63: lcdfc_glyph = 8'h39;
         8'h44, 8'h64: lcdfc_glyph = 8'h5E;
         8'h45, 8'h65: lcdfc_glyph = 8'h79;
         8'h46, 8'h66: lcdfc_glyph = 8'h71;
         8'h2D: lcdfc_glyph = 8'h40;
         default: lcdfc_glyph = 8'h00;
      endcase
   endfunction : lcdfc_glyph

   logic [7:0] ctrl, next_ctrl;
   logic [7:0] timing, next_timing;
   logic [4:0] xint, next_xint;
   logic [7:0] blink_ctrl, next_blink_ctrl;
   logic [7:0] blink_sel, next_blink_sel;
   logic [7:0] digit, next_digit;
   logic [7:0] next_reg_rdata;
   logic lcd_sync1, lcd_sync2, lcd_prev;
   logic [3:0] ripple, next_ripple;
   logic [2:0] div_cnt, next_div_cnt;
   logic [1:0] com_idx, next_com_idx;
   logic phase, next_phase;
   logic lp_pol, next_lp_pol;
   logic lp_half, next_lp_half;
   logic [4:0] irq_cnt, next_irq_cnt;
   logic next_frame_flag;
   logic blanked, next_blanked;
   logic blink_en_q, next_blink_en_q;
   logic [7:0] blink_sel_q, next_blink_sel_q;
   logic [1:0] blink_rate_q, next_blink_rate_q;
   logic [7:0] blink_cnt, next_blink_cnt;
   logic blink_off, next_blink_off;
   logic [3:0][39:0] dmem, next_dmem;
   logic [3:0][39:0] shadow, next_shadow;
   logic [7:0] next_com_level;
   logic [79:0] next_seg_level;
   logic [39:0] seg_on;
   logic lcd_edge, rip_wrap, ps_tick, slot_end, last_com, frame_end, irq_evt;
   logic [3:0] ripple_tc;
   logic [2:0] ncoms;
   logic [7:0] blink_lim;
   logic pol, enable, low_power, wr_dmem, wr_ascii, wr_clear;

   assign enable = ctrl[lcdfc_pkg::CTRL_ENABLE];
   assign low_power = timing[lcdfc_pkg::TIM_LOW_POWER];
   assign ncoms = lcdfc_num_coms(timing[lcdfc_pkg::TIM_DUTY_LSB +: 2]);
   assign wr_dmem = reg_wr && reg_addr >= lcdfc_pkg::OFS_DMEM
                    && reg_addr < lcdfc_pkg::OFS_DMEM + 6'(lcdfc_pkg::DMEM_BYTES);
   assign wr_ascii = reg_wr && reg_addr == lcdfc_pkg::OFS_ASCII;
   assign wr_clear = reg_wr && reg_addr == lcdfc_pkg::OFS_CTRL
                     && reg_wdata[lcdfc_pkg::CTRL_CLEAR];

   // Edge of the 32 kHz LCD clock; the second stage and its delayed copy feed the detector
   assign lcd_edge = lcd_sync2 & ~lcd_prev; // [R21]
   // Prescaler and frame divider strobes
   assign ripple_tc = timing[lcdfc_pkg::TIM_PRESCALE] ? lcdfc_pkg::RIPPLE_TC_16
                                                      : lcdfc_pkg::RIPPLE_TC_8; // [R1]
   assign rip_wrap = enable && lcd_edge && ripple == ripple_tc; // [R1] no slot ends while off
   assign ps_tick = rip_wrap && div_cnt >= timing[lcdfc_pkg::TIM_DIV_LSB +: 3]; // [R2]
   // Slot and frame boundaries; low power uses one slot per common
   assign slot_end = low_power | phase; // [R9]
   assign last_com = {1'b0, com_idx} >= ncoms - 3'h1; // [R6]
   assign frame_end = ps_tick && last_com && slot_end;
   assign pol = low_power ? lp_pol : ~phase; // [R9]
   assign irq_evt = frame_end && (!low_power || lp_half); // [R9]
   assign blink_lim = (lcdfc_pkg::BLINK_BASE << blink_rate_q) - 8'h01; // [R15]

   // Timing next state: prescaler, divider, common scan, frame counters
   always_comb
   begin
      next_ripple = ripple;
      next_div_cnt = div_cnt;
      next_com_idx = com_idx;
      next_phase = phase;
      next_lp_pol = lp_pol;
      next_lp_half = lp_half;
      next_irq_cnt = irq_cnt;
      next_blink_cnt = blink_cnt;
      next_blink_off = blink_off;
      if (!enable)
      begin
         next_ripple = 4'h0;
         next_div_cnt = 3'h0;
         next_com_idx = 2'h0;
         next_phase = 1'b0;
      end
      else
      begin
         // No sleep gating: the scan runs whenever enabled [R10]
         if (lcd_edge)
            next_ripple = rip_wrap ? 4'h0 : ripple + 4'h1; // [R1]
         if (rip_wrap)
            next_div_cnt = ps_tick ? 3'h0 : div_cnt + 3'h1; // [R2]
         if (ps_tick)
         begin
            next_phase = ~slot_end;
            if (slot_end)
               next_com_idx = last_com ? 2'h0 : com_idx + 2'h1; // [R5] [R6]
         end
         if (frame_end)
         begin
            next_lp_pol = ~lp_pol; // [R9]
            next_lp_half = low_power ? ~lp_half : 1'b0; // [R9]
            next_blink_cnt = blink_cnt >= blink_lim ? 8'h00 : blink_cnt + 8'h01;
            if (blink_cnt >= blink_lim)
               next_blink_off = ~blink_off; // [R15]
         end
         if (irq_evt)
            next_irq_cnt = irq_cnt >= xint ? 5'h00 : irq_cnt + 5'h01; // [R20]
      end
   end

   // Timing registers
   always_ff @(posedge clk)
   begin
      if (sys_rst)
      begin
         lcd_sync1 <= 1'b0;
         lcd_sync2 <= 1'b0;
         lcd_prev <= 1'b0;
         ripple <= 4'h0;
         div_cnt <= 3'h0;
         com_idx <= 2'h0;
         phase <= 1'b0;
         lp_pol <= 1'b0;
         lp_half <= 1'b0;
         irq_cnt <= 5'h00;
         blink_cnt <= 8'h00;
         blink_off <= 1'b0;
      end
      else
      begin
         lcd_sync1 <= lcd_clk_in;
         lcd_sync2 <= lcd_sync1;
         lcd_prev <= lcd_sync2;
         ripple <= next_ripple;
         div_cnt <= next_div_cnt;
         com_idx <= next_com_idx;
         phase <= next_phase;
         lp_pol <= next_lp_pol;
         lp_half <= next_lp_half;
         irq_cnt <= next_irq_cnt;
         blink_cnt <= next_blink_cnt;
         blink_off <= next_blink_off;
      end
   end

   // Register file next state, flag, blanking and blink latches
   always_comb
   begin
      next_ctrl = ctrl;
      next_timing = timing;
      next_xint = xint;
      next_blink_ctrl = blink_ctrl;
      next_blink_sel = blink_sel;
      next_digit = digit;
      next_reg_rdata = 8'h00;
      if (reg_wr)
      begin
         unique case (reg_addr)
            lcdfc_pkg::OFS_CTRL: next_ctrl = reg_wdata & ~(8'h01 << lcdfc_pkg::CTRL_CLEAR);
            lcdfc_pkg::OFS_TIMING: next_timing = reg_wdata;
            lcdfc_pkg::OFS_XINT: next_xint = reg_wdata[4:0];
            lcdfc_pkg::OFS_BLINK_CTRL: next_blink_ctrl = reg_wdata & 8'h0B;
            lcdfc_pkg::OFS_BLINK_SEL: next_blink_sel = reg_wdata;
            lcdfc_pkg::OFS_DIGIT: next_digit = reg_wdata;
            default: ;
         endcase
      end
      if (reg_rd)
      begin
         unique case (reg_addr)
            lcdfc_pkg::OFS_CTRL: next_reg_rdata = ctrl;
            lcdfc_pkg::OFS_TIMING: next_reg_rdata = timing;
            lcdfc_pkg::OFS_XINT: next_reg_rdata = {3'h0, xint};
            lcdfc_pkg::OFS_STATUS: next_reg_rdata = {3'h0, blink_off, com_idx, blanked, frame_flag};
            lcdfc_pkg::OFS_BLINK_CTRL: next_reg_rdata = blink_ctrl;
            lcdfc_pkg::OFS_BLINK_SEL: next_reg_rdata = blink_sel;
            lcdfc_pkg::OFS_DIGIT: next_reg_rdata = digit;
            default:
               if (reg_addr >= lcdfc_pkg::OFS_DMEM
                   && reg_addr < lcdfc_pkg::OFS_DMEM + 6'(lcdfc_pkg::DMEM_BYTES))
                  next_reg_rdata = dmem[(reg_addr - lcdfc_pkg::OFS_DMEM) / 6'd5]
                                       [((reg_addr - lcdfc_pkg::OFS_DMEM) % 6'd5) * 8 +: 8];
         endcase
      end
      // Set wins over a write-one clear in the same cycle
      next_frame_flag = (irq_evt && irq_cnt >= xint)
                        || (frame_flag && !(reg_wr && reg_addr == lcdfc_pkg::OFS_STATUS
                                            && reg_wdata[lcdfc_pkg::STAT_FLAG])); // [R20] [R23]
      // Blanking engages only at frame end, releases at once
      next_blanked = ctrl[lcdfc_pkg::CTRL_BLANK] && (blanked || frame_end); // [R12]
      next_blink_en_q = blink_en_q;
      next_blink_sel_q = blink_sel_q;
      next_blink_rate_q = blink_rate_q;
      if (frame_end)
      begin
         next_blink_en_q = blink_ctrl[lcdfc_pkg::BLK_ENABLE]; // [R19]
         next_blink_sel_q = blink_sel; // [R19]
         next_blink_rate_q = blink_ctrl[lcdfc_pkg::BLK_RATE_LSB +: 2]; // [R19]
      end
   end

   // Register file registers
   always_ff @(posedge clk)
   begin
      if (sys_rst)
      begin
         ctrl <= lcdfc_pkg::RST_CTRL;
         timing <= lcdfc_pkg::RST_TIMING;
         xint <= lcdfc_pkg::RST_XINT;
         blink_ctrl <= lcdfc_pkg::RST_BLINK_CTRL;
         blink_sel <= lcdfc_pkg::RST_BLINK_SEL;
         digit <= lcdfc_pkg::RST_DIGIT;
         reg_rdata <= 8'h00;
         frame_flag <= 1'b0;
         blanked <= 1'b0;
         blink_en_q <= 1'b0;
         blink_sel_q <= 8'h00;
         blink_rate_q <= 2'h0;
      end
      else
      begin
         ctrl <= next_ctrl;
         timing <= next_timing;
         xint <= next_xint;
         blink_ctrl <= next_blink_ctrl;
         blink_sel <= next_blink_sel;
         digit <= next_digit;
         reg_rdata <= next_reg_rdata;
         frame_flag <= next_frame_flag;
         blanked <= next_blanked;
         blink_en_q <= next_blink_en_q;
         blink_sel_q <= next_blink_sel_q;
         blink_rate_q <= next_blink_rate_q;
      end
   end

   // Display memory writes, clear, digit decoder and shadow copy
   always_comb
   begin
      int w;
      int c;
      int s;
      int idx;
      logic [7:0] pat;
      w = 2;
      c = 0;
      s = 0;
      idx = int'(reg_addr - lcdfc_pkg::OFS_DMEM);
      pat = lcdfc_glyph(reg_wdata);
      next_dmem = dmem;
      if (wr_clear)
         next_dmem = '0;
      else if (wr_dmem)
         next_dmem[idx / lcdfc_pkg::BYTES_PER_COM][(idx % lcdfc_pkg::BYTES_PER_COM) * 8 +: 8]
            = reg_wdata;
      else if (wr_ascii)
      begin
         // Mapping type sets segments per common: 2, 3, 4 or 8 [R11]
         unique case (digit[lcdfc_pkg::DIG_TYPE_LSB +: 2])
            2'h0: w = 2;
            2'h1: w = 3;
            2'h2: w = 4;
            2'h3: w = 8;
         endcase
         for (int k = 0; k < 8; k++)
         begin
            c = k / w;
            s = int'(digit[7:lcdfc_pkg::DIG_BASE_LSB]) + k % w;
            if (c < lcdfc_pkg::N_COM && s < lcdfc_pkg::N_SEG)
               next_dmem[c][s] = pat[k]; // [R11]
         end
      end
      // Frame start refresh unless locked [R3] [R22]
      next_shadow = (frame_end && !ctrl[lcdfc_pkg::CTRL_DATA_LOCK]) ? dmem : shadow;
   end

   // Display memory registers
   always_ff @(posedge clk)
   begin
      if (sys_rst)
      begin
         dmem <= '0;
         shadow <= '0;
      end
      else
      begin
         dmem <= next_dmem;
         shadow <= next_shadow;
      end
   end

   // Per segment on state for the addressed common, with blink masking
   for (genvar g = 0; g < lcdfc_pkg::N_SEG; g++)
   begin : g_seg
      logic hit;
      if (g < 2)
      begin : g_blink_pin
         assign hit = blink_sel_q == 8'h00 || blink_sel_q[g * 4 + com_idx]; // [R15] [R17]
      end
      else
      begin : g_plain_pin
         assign hit = blink_sel_q == 8'h00; // [R17] [R18]
      end
      assign seg_on[g] = shadow[com_idx][g] && ctrl[lcdfc_pkg::CTRL_SEG_ON]
                         && !(blink_en_q && blink_off && hit); // [R4] [R13] [R16]
   end

   // Waveform decoder: level code per pin, one-third bias beyond static
   always_comb
   begin
      next_com_level = '0;
      next_seg_level = '0;
      if (enable && !blanked) // [R12]
      begin
         for (int c = 0; c < lcdfc_pkg::N_COM; c++)
            if (c < int'(ncoms))
            begin
               if (c == int'(com_idx) || ncoms == 3'h1)
                  next_com_level[c * 2 +: 2] = pol ? lcdfc_pkg::LVL_FULL : lcdfc_pkg::LVL_GND;
               else
                  next_com_level[c * 2 +: 2] = pol ? lcdfc_pkg::LVL_THIRD
                                                   : lcdfc_pkg::LVL_TWO_THIRD; // [R8]
            end
         for (int s = 0; s < lcdfc_pkg::N_SEG; s++)
            if (seg_on[s])
               next_seg_level[s * 2 +: 2] = pol ? lcdfc_pkg::LVL_GND : lcdfc_pkg::LVL_FULL; // [R7]
            else if (ncoms == 3'h1)
               next_seg_level[s * 2 +: 2] = pol ? lcdfc_pkg::LVL_FULL : lcdfc_pkg::LVL_GND;
            else
               next_seg_level[s * 2 +: 2] = pol ? lcdfc_pkg::LVL_TWO_THIRD
                                                : lcdfc_pkg::LVL_THIRD; // [R7] [R8]
      end
   end

   // Pin level registers
   always_ff @(posedge clk)
   begin
      if (sys_rst)
      begin
         com_level <= '0;
         seg_level <= '0;
      end
      else
      begin
         com_level <= next_com_level;
         seg_level <= next_seg_level;
      end
   end

   // Checks on the design's own behaviour
   default clocking lcdfc_cb @(posedge clk); endclocking
   default disable iff (sys_rst);

   ripple_step_a: assert property (lcd_edge && enable && !rip_wrap |=> ripple == $past(ripple) + 4'h1) // [R1]
      else $error("ripple counter did not advance");
   div_step_a: assert property (rip_wrap && enable && !ps_tick |=> div_cnt == $past(div_cnt) + 3'h1) // [R2]
      else $error("frame divider did not advance");
   shadow_copy_a: assert property (frame_end && !ctrl[lcdfc_pkg::CTRL_DATA_LOCK] |=> shadow == $past(dmem)) // [R3]
      else $error("shadow not refreshed at frame start");
   lock_hold_a: assert property (ctrl[lcdfc_pkg::CTRL_DATA_LOCK] |=> $stable(shadow)) // [R22]
      else $error("shadow changed while locked");
   first_com_a: assert property (frame_end |=> com_idx == 2'h0) // [R5]
      else $error("frame did not restart at first common");
   com_walk_a: assert property (ps_tick && slot_end && !last_com |=> com_idx == $past(com_idx) + 2'h1) // [R6]
      else $error("common scan skipped");
   blank_pins_a: assert property (blanked |=> com_level == 8'h00 && seg_level == '0) // [R12]
      else $error("pins not grounded while blanked");
   blank_wait_a: assert property ($rose(blanked) |-> $past(frame_end)) // [R12]
      else $error("blanking began mid frame");
   seg_off_a: assert property (!ctrl[lcdfc_pkg::CTRL_SEG_ON] |-> seg_on == '0) // [R13]
      else $error("segment shown with segments off");
   lp_skip_a: assert property (frame_end && low_power && !lp_half |=> !$rose(frame_flag)) // [R9]
      else $error("flag set on odd low power frame");
   irq_count_a: assert property ($rose(frame_flag) |-> $past(irq_evt && irq_cnt >= xint)) // [R20]
      else $error("frame flag at wrong frame count");
   flag_hold_a: assert property (frame_flag && !(reg_wr && reg_addr == lcdfc_pkg::OFS_STATUS) |=> frame_flag) // [R23]
      else $error("frame flag dropped without clear");

   frame_seen_c: cover property (frame_end ##1 !frame_end [*2]);
   blank_seen_c: cover property ($rose(blanked));
   lp_flag_c: cover property (low_power && $rose(frame_flag));
   blink_seen_c: cover property (blink_en_q && $rose(blink_off));
endmodule : lcdfc_top
`default_nettype wire

// ===== bench/lcdfc_panel.sv
// Passive segment panel model that records which cells see full drive
`timescale 1ns/10ps
`default_nettype none
module lcdfc_panel (
   input wire logic clk,
   input wire logic [1:0] duty,
   input wire logic [7:0] com_level,
   input wire logic [79:0] seg_level,
   output logic [159:0] lit
);
   int n_com;
   logic [1:0] cl;
   assign n_com = (duty == 2'h0) ? 4 : int'(duty);
   // An addressed common sits at an extreme level; a cell across full swing is lit
   always @(posedge clk)
   begin
      for (int c = 0; c < 4; c++)
      begin
         cl = com_level[2*c+:2];
         if (c < n_com && (cl == 2'h3 || cl == 2'h0))
         begin
            for (int s = 0; s < 40; s++)
               lit[c*40+s] <= (seg_level[2*s+:2] ^ cl) == 2'h3;
         end
      end
   end
endmodule : lcdfc_panel
`default_nettype wire

// ===== bench/lcdfc_top_tb.sv
// Self-checking bench for the segment LCD frame controller
`timescale 1ns/10ps
`default_nettype none
module lcdfc_top_tb;
   logic clk = 1'b0;
   logic sys_rst = 1'b1;
   logic lcd_clk_in = 1'b0;
   logic [5:0] reg_addr = 6'h00;
   logic [7:0] reg_wdata = 8'h00;
   logic reg_wr = 1'b0;
   logic reg_rd = 1'b0;
   logic [7:0] reg_rdata;
   logic [7:0] com_level;
   logic [79:0] seg_level;
   logic frame_flag;
   logic [159:0] lit;
   logic [159:0] old;
   logic [1:0] duty = 2'h0;
   logic [2:0] lcd_cnt = 3'h0;
   logic [7:0] m [20];
   logic [7:0] d;
   logic [7:0] sel;
   logic [159:0] mask;
   int n_off;
   int failures = 0;
   int compares = 0;
   int cyc = 0;
   int t0;
   logic [5:0] ofs [8] = '{6'h00, 6'h01, 6'h02, 6'h03, 6'h04, 6'h05, 6'h07, 6'h3F};
   logic [7:0] tim [4] = '{8'h00, 8'hF1, 8'h3A, 8'h13};
   logic [7:0] xin [4] = '{8'h00, 8'h00, 8'h00, 8'h02};
   int ex [4] = '{512, 2048, 1024, 2304};

   lcdfc_top u_lcdfc_top (.clk(clk), .sys_rst(sys_rst), .lcd_clk_in(lcd_clk_in),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .reg_rdata(reg_rdata), .com_level(com_level), .seg_level(seg_level),
      .frame_flag(frame_flag));
   lcdfc_panel u_lcdfc_panel (.clk(clk), .duty(duty), .com_level(com_level),
      .seg_level(seg_level), .lit(lit));

   // 50 MHz system clock
   initial
   begin
      forever #10 clk = ~clk;
   end

   // Fast stand-in for the slow LCD clock (eight cycles a period) and the watchdog
   always @(posedge clk)
   begin
      lcd_cnt <= lcd_cnt + 3'h1;
      lcd_clk_in <= lcd_cnt[2];
      cyc <= cyc + 1;
      if (cyc == 80000)
      begin
         failures++;
         complete_run();
      end
   end

   task automatic check(string what, logic [159:0] seen, logic [159:0] exp);
      compares++;
      if (seen !== exp)
      begin
         failures++;
         $display("[ERR] %s expected %0h seen %0h", what, exp, seen);
      end
   endtask : check

   task automatic wr(logic [5:0] a, logic [7:0] v);
      @(posedge clk);
      reg_addr <= a;
      reg_wdata <= v;
      reg_wr <= 1'b1;
      @(posedge clk);
      reg_wr <= 1'b0;
   endtask : wr

   task automatic rd(logic [5:0] a);
      @(posedge clk);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge clk);
      reg_rd <= 1'b0;
      @(negedge clk);
      d = reg_rdata;
   endtask : rd

   // Clear the frame flag and wait until the frame flag is set again
   task automatic next_flag();
      wr(lcdfc_pkg::OFS_STATUS, 8'h01);
      do @(negedge clk); while (frame_flag !== 1'b1);
   endtask : next_flag

   // Reference display memory, loaded with fresh random bytes
   task automatic fill();
      for (int i = 0; i < 20; i++)
      begin
         m[i] = 8'($urandom);
         wr(6'(lcdfc_pkg::OFS_DMEM + i), m[i]);
      end
   endtask : fill

   function automatic logic [159:0] flat();
      logic [159:0] f;
      for (int i = 0; i < 20; i++)
         f[i*8+:8] = m[i];
      return f;
   endfunction : flat

   task automatic complete_run();
      $display("compares %0d failures %0d", compares, failures);
      if (failures == 0 && compares > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask : complete_run

   // Main sequence
   initial
   begin
      void'($urandom(12));
      repeat (20) @(posedge clk);
      sys_rst <= 1'b0;
      for (int i = 0; i < 8; i++)
      begin
         rd(ofs[i]);
         check("reset value", d, 8'h00);
      end
      $display("test reset done");
      fill();
      wr(lcdfc_pkg::OFS_CTRL, 8'h82);
      next_flag();
      next_flag();
      check("panel cells", lit, flat());
      wr(lcdfc_pkg::OFS_CTRL, 8'hA2);
      old = flat();
      fill();
      next_flag();
      next_flag();
      check("locked cells", lit, old);
      wr(lcdfc_pkg::OFS_CTRL, 8'h82);
      next_flag();
      next_flag();
      check("unlocked cells", lit, flat());
      $display("test display done");
      // Hardware blink on the first two segment pins with a random common selection
      for (int i = 0; i < 20; i += 5)
      begin
         m[i] = m[i] | 8'h03;
         wr(6'(lcdfc_pkg::OFS_DMEM + i), m[i]);
      end
      sel = 8'($urandom);
      for (int i = 0; i < 160; i++)
         mask[i] = sel == 8'h00 || (i % 40 < 2 && sel[(i % 40) * 4 + i / 40]);
      wr(lcdfc_pkg::OFS_BLINK_SEL, sel);
      wr(lcdfc_pkg::OFS_BLINK_CTRL, 8'h08);
      next_flag();
      n_off = 0;
      for (int f = 0; f < 4 * lcdfc_pkg::BLINK_BASE; f++)
      begin
         next_flag();
         if (lit !== flat())
         begin
            n_off++;
            check("blink cells", lit, flat() & ~mask);
         end
      end
      check("blink off frames", 160'(n_off), 160'(2 * lcdfc_pkg::BLINK_BASE));
      $display("test blink done");
      wr(lcdfc_pkg::OFS_CTRL, 8'h80);
      next_flag();
      next_flag();
      check("segments off", lit, '0);
      check("commons active", |com_level, 1'b1);
      wr(lcdfc_pkg::OFS_CTRL, 8'h83);
      repeat (1200) @(posedge clk);
      check("blanked pins", {com_level, seg_level}, '0);
      rd(6'(lcdfc_pkg::OFS_DMEM + 3));
      check("kept memory", d, m[3]);
      $display("test blanking done");
      // Clear memory, then decode an ASCII one into the second byte of the first common
      wr(lcdfc_pkg::OFS_CTRL, 8'h86);
      wr(lcdfc_pkg::OFS_DIGIT, 8'h23);
      wr(lcdfc_pkg::OFS_ASCII, 8'h31);
      rd(6'(lcdfc_pkg::OFS_DMEM + 1));
      check("digit pattern", d, 8'h06);
      rd(lcdfc_pkg::OFS_DMEM);
      check("digit neighbour", d, 8'h00);
      $display("test digit done");
      for (int k = 0; k < 4; k++)
      begin
         duty = tim[k][1:0];
         wr(lcdfc_pkg::OFS_TIMING, tim[k]);
         wr(lcdfc_pkg::OFS_XINT, xin[k]);
         wr(lcdfc_pkg::OFS_CTRL, 8'h82);
         next_flag();
         next_flag();
         t0 = cyc;
         next_flag();
         check("flag interval", 160'(cyc - t0), 160'(ex[k]));
      end
      $display("test timing done");
      complete_run();
   end
endmodule : lcdfc_top_tb
`default_nettype wire
